// file: iofp_cfg.svh
/*
  Constants of the OR-into-file and pointer-load execution block: APB offsets,
  field positions, reset values and opcodes.
  Assumes inclusion by bare name from the package and the core module.
*/
// Notes on behaviour
// [RULE_01] OR work register with file register, set negative and zero, destination 0 writes work.
// [RULE_02] Destination 1 writes the OR result back into the addressed file register.
// [RULE_03] Access bit 0 resolves the file address through the fixed access bank.
// [RULE_04] Access bit 1 takes the data bank from the bank select register.
// [RULE_05] Extended set, access bit 0, address up to 95 means indexed literal offset.
// [RULE_06] Pointer load puts a 12-bit literal into pointer 0, 1 or 2 only.
// [RULE_07] Pointer load takes two cycles: high byte first, then low byte.
`ifndef IOFP_CFG_SVH
`define IOFP_CFG_SVH

// Register byte offsets on the APB.
`define IOFP_OFS_INSTR    8'h00
`define IOFP_OFS_WORK     8'h04
`define IOFP_OFS_STATUS   8'h08
`define IOFP_OFS_BANK     8'h0c
`define IOFP_OFS_CFG      8'h10
`define IOFP_OFS_PTR0     8'h14
`define IOFP_OFS_PTR1     8'h18
`define IOFP_OFS_PTR2     8'h1c
`define IOFP_OFS_RAMADDR  8'h20
`define IOFP_OFS_RAMDATA  8'h24

// Status and configuration bit positions.
`define IOFP_ST_ZERO      0
`define IOFP_ST_NEG       1
`define IOFP_ST_PEND      2
`define IOFP_ST_BAD       3
`define IOFP_CFG_EXT      0

// Instruction encodings.
`define IOFP_OP_IOR       6'h04
`define IOFP_OP_LDPTR1    8'hee
`define IOFP_OP_LDPTR2    8'hf0
`define IOFP_SEL_BAD      2'h3

// Access bank split and its upper half.
`define IOFP_ACC_LIMIT    8'h5f
`define IOFP_ACC_HI_BANK  4'hf
`define IOFP_BANK_LO      4'h0

// Reset values.
`define IOFP_RST_BYTE     8'h00
`define IOFP_RST_PTR      12'h000
`define IOFP_RST_WORD     32'h0000_0000

`endif

// file: iofp_pkg.sv
/*
  Types shared by the execution block: sequencer states and instruction fields.
  Assumes the constants header is on the include path.
*/
package iofp_pkg;
  `include "iofp_cfg.svh"

  // Sequencer states, Gray coded along idle, execute, wait, second execute.
  typedef enum logic [1:0] {
    IOFP_IDLE  = 2'b00,
    IOFP_EXEC  = 2'b01,
    IOFP_WAIT2 = 2'b11,
    IOFP_EXEC2 = 2'b10
  } iofp_state_t;

  // Fields of the OR-into-file instruction word.
  typedef struct packed {
    logic [5:0] op;
    logic       dest;
    logic       acc;
    logic [7:0] f;
  } iofp_ior_t;

  // Result flags kept by the block.
  typedef struct packed {
    logic neg;
    logic zero;
  } iofp_flags_t;
endpackage

// file: iofp_core.sv
/*
  Executes the OR-into-file and pointer-load instructions handed in over APB,
  with its own data memory, work register, bank select and three pointers.
  Assumes an APB master; instructions are written as 16-bit words to INSTR.
*/
`timescale 1ns/10ps
`include "iofp_cfg.svh"
module iofp_core import iofp_pkg::*; #(
  parameter int RAM_AW   = 12,
  parameter int PTR_NUM  = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // The addressing logic forms 12-bit data addresses and three pointers.
  if (RAM_AW != 12 || PTR_NUM != 3) begin : g_check
    $error("iofp_core supports only RAM_AW 12 and PTR_NUM 3");
  end

  logic [7:0]        ram [0:(1<<RAM_AW)-1];
  iofp_state_t       state_ff, nxt_state;
  logic [15:0]       ir_ff, nxt_ir;
  logic [7:0]        work_ff, nxt_work;
  iofp_flags_t       flags_ff, nxt_flags;
  logic [3:0]        bank_ff, nxt_bank;
  logic              ext_ff, nxt_ext;
  logic              bad_ff, nxt_bad;
  logic [1:0]        sel_ff, nxt_sel;
  logic [11:0]       ptr_ff [PTR_NUM];
  logic [11:0]       nxt_ptr [PTR_NUM];
  logic [11:0]       raddr_ff, nxt_raddr;
  logic              pready_ff, nxt_pready;
  logic              pslverr_ff, nxt_pslverr;
  logic [31:0]       prdata_ff, nxt_prdata;
  logic              ram_we;
  logic [11:0]       ram_wa;
  logic [7:0]        ram_wd;
  logic              wr_go;
  iofp_ior_t         ior;
  logic [11:0]       eff_addr;
  logic [7:0]        or_res;
  logic              is_ior;
  logic              is_ld1;
  logic [2:0]        pa_ptr;

  // Maps an 8-bit offset to a register hit; used by both read and write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pointer registers occupy consecutive words after the first pointer.
  function automatic logic [2:0] ptr_hit(input logic [7:0] a);
    ptr_hit = {hit(a, `IOFP_OFS_PTR2), hit(a, `IOFP_OFS_PTR1), hit(a, `IOFP_OFS_PTR0)};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `IOFP_OFS_INSTR) | hit(a, `IOFP_OFS_WORK) | hit(a, `IOFP_OFS_STATUS) |
             hit(a, `IOFP_OFS_BANK) | hit(a, `IOFP_OFS_CFG) | (|ptr_hit(a)) |
             hit(a, `IOFP_OFS_RAMADDR) | hit(a, `IOFP_OFS_RAMDATA);
  endfunction

  // Pointer hits of the bus address, kept in a net because a call result cannot be bit-selected.
  assign pa_ptr = ptr_hit(paddr);

  // Resolves the 8-bit file operand to a full data address.
  function automatic logic [11:0] resolve(input logic acc, input logic [7:0] f, input logic [3:0] bank,
                                          input logic ext, input logic [11:0] base);
    if (acc) begin
      resolve = {bank, f}; // RULE_04
    end else if (ext && f <= `IOFP_ACC_LIMIT) begin
      resolve = base + {`IOFP_BANK_LO, f}; // RULE_05
    end else if (f <= `IOFP_ACC_LIMIT) begin
      resolve = {`IOFP_BANK_LO, f}; // RULE_03
    end else begin
      resolve = {`IOFP_ACC_HI_BANK, f}; // RULE_03
    end
  endfunction

  // Instruction decode and the OR datapath; pointer 2 is the indexed base.
  always_comb begin
    ior      = iofp_ior_t'(ir_ff);
    is_ior   = (ior.op == `IOFP_OP_IOR);
    is_ld1   = (ir_ff[15:8] == `IOFP_OP_LDPTR1) && (ir_ff[7:6] == 2'b00);
    eff_addr = resolve(ior.acc, ior.f, bank_ff, ext_ff, ptr_ff[2]);
    or_res   = work_ff | ram[eff_addr]; // RULE_01
  end

  // APB answers one cycle into the access phase, so pready is registered.
  always_comb begin
    wr_go       = psel & penable & pwrite & pready_ff;
    nxt_pready  = psel & penable & ~pready_ff;
    nxt_pslverr = psel & penable & ~pready_ff & ~mapped(paddr);
    nxt_prdata  = prdata_ff;
    if (psel & penable & ~pready_ff & ~pwrite) begin
      nxt_prdata = `IOFP_RST_WORD;
      unique case (1'b1)
        hit(paddr, `IOFP_OFS_WORK):    nxt_prdata[7:0] = work_ff;
        hit(paddr, `IOFP_OFS_STATUS): begin
          nxt_prdata[`IOFP_ST_ZERO] = flags_ff.zero;
          nxt_prdata[`IOFP_ST_NEG]  = flags_ff.neg;
          nxt_prdata[`IOFP_ST_PEND] = (state_ff == IOFP_WAIT2);
          nxt_prdata[`IOFP_ST_BAD]  = bad_ff;
        end
        hit(paddr, `IOFP_OFS_BANK):    nxt_prdata[3:0] = bank_ff;
        hit(paddr, `IOFP_OFS_CFG):     nxt_prdata[`IOFP_CFG_EXT] = ext_ff;
        pa_ptr[0]:                     nxt_prdata[11:0] = ptr_ff[0];
        pa_ptr[1]:                     nxt_prdata[11:0] = ptr_ff[1];
        pa_ptr[2]:                     nxt_prdata[11:0] = ptr_ff[2];
        hit(paddr, `IOFP_OFS_RAMADDR): nxt_prdata[11:0] = raddr_ff;
        hit(paddr, `IOFP_OFS_RAMDATA): nxt_prdata[7:0] = ram[raddr_ff];
        default:                       nxt_prdata = `IOFP_RST_WORD;
      endcase
    end
  end

  // Sequencer and architectural state. An instruction write is executed in the
  // following cycle; the next APB write cannot land before that cycle is over.
  always_comb begin
    nxt_state = state_ff;
    nxt_ir    = ir_ff;
    nxt_work  = work_ff;
    nxt_flags = flags_ff;
    nxt_bank  = bank_ff;
    nxt_ext   = ext_ff;
    nxt_bad   = bad_ff;
    nxt_sel   = sel_ff;
    nxt_raddr = raddr_ff;
    for (int i = 0; i < PTR_NUM; i++) begin
      nxt_ptr[i] = ptr_ff[i];
    end
    ram_we = 1'b0;
    ram_wa = raddr_ff;
    ram_wd = pwdata[7:0];
    if (wr_go) begin
      if (hit(paddr, `IOFP_OFS_WORK))    nxt_work = pwdata[7:0];
      if (hit(paddr, `IOFP_OFS_BANK))    nxt_bank = pwdata[3:0];
      if (hit(paddr, `IOFP_OFS_CFG))     nxt_ext = pwdata[`IOFP_CFG_EXT];
      if (hit(paddr, `IOFP_OFS_RAMADDR)) nxt_raddr = pwdata[11:0];
      if (hit(paddr, `IOFP_OFS_RAMDATA)) ram_we = 1'b1;
      if (hit(paddr, `IOFP_OFS_STATUS))  nxt_bad = 1'b0;
      for (int i = 0; i < PTR_NUM; i++) begin
        if (pa_ptr[i]) nxt_ptr[i] = pwdata[11:0];
      end
    end
    unique case (state_ff)
      IOFP_IDLE, IOFP_WAIT2: begin
        if (wr_go && hit(paddr, `IOFP_OFS_INSTR)) begin
          nxt_ir    = pwdata[15:0];
          nxt_state = (state_ff == IOFP_IDLE) ? IOFP_EXEC : IOFP_EXEC2;
        end
      end
      IOFP_EXEC: begin
        nxt_state = IOFP_IDLE;
        if (is_ior) begin
          nxt_flags.neg  = or_res[7]; // RULE_01
          nxt_flags.zero = (or_res == `IOFP_RST_BYTE); // RULE_01
          if (ior.dest) begin
            ram_we = 1'b1; // RULE_02
            ram_wa = eff_addr;
            ram_wd = or_res;
          end else begin
            nxt_work = or_res; // RULE_01
          end
        end else if (is_ld1 && ir_ff[5:4] != `IOFP_SEL_BAD) begin
          nxt_sel                 = ir_ff[5:4]; // RULE_06
          nxt_ptr[ir_ff[5:4]][11:8] = ir_ff[3:0]; // RULE_07
          nxt_state               = IOFP_WAIT2;
        end else begin
          nxt_bad = 1'b1; // RULE_06
        end
      end
      IOFP_EXEC2: begin
        nxt_state = IOFP_IDLE;
        if (ir_ff[15:8] == `IOFP_OP_LDPTR2) begin
          nxt_ptr[sel_ff][7:0] = ir_ff[7:0]; // RULE_07
        end else begin
          nxt_bad = 1'b1;
        end
      end
    endcase
  end

  // Register stage for all state above.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= IOFP_IDLE;
      ir_ff      <= '0;
      work_ff    <= `IOFP_RST_BYTE;
      flags_ff   <= '0;
      bank_ff    <= '0;
      ext_ff     <= 1'b0;
      bad_ff     <= 1'b0;
      sel_ff     <= '0;
      raddr_ff   <= `IOFP_RST_PTR;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `IOFP_RST_WORD;
      for (int i = 0; i < PTR_NUM; i++) begin
        ptr_ff[i] <= `IOFP_RST_PTR;
      end
    end else begin
      state_ff   <= nxt_state;
      ir_ff      <= nxt_ir;
      work_ff    <= nxt_work;
      flags_ff   <= nxt_flags;
      bank_ff    <= nxt_bank;
      ext_ff     <= nxt_ext;
      bad_ff     <= nxt_bad;
      sel_ff     <= nxt_sel;
      raddr_ff   <= nxt_raddr;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      for (int i = 0; i < PTR_NUM; i++) begin
        ptr_ff[i] <= nxt_ptr[i];
      end
    end
  end

  // Data memory has no reset; software must initialise it.
  always_ff @(posedge pclk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_or_to_work: assert property ((state_ff == IOFP_EXEC && is_ior && !ior.dest) |=> // RULE_01
    (work_ff == $past(or_res)) && (flags_ff.zero == ($past(or_res) == 8'h00)) && (flags_ff.neg == $past(or_res[7])))
    else $error("OR result not placed in work register with flags");
  a_or_to_file: assert property ((state_ff == IOFP_EXEC && is_ior && ior.dest) |=> // RULE_02
    (ram[$past(eff_addr)] == $past(or_res)) && $stable(work_ff))
    else $error("OR result not written back to file register");
  a_access_bank: assert property ((is_ior && !ior.acc && !(ext_ff && ior.f <= 8'h5f)) |-> // RULE_03
    (eff_addr[11:8] == ((ior.f > 8'h5f) ? 4'hf : 4'h0)) && (eff_addr[7:0] == ior.f))
    else $error("Access bank address wrong");
  a_bank_select: assert property ((is_ior && ior.acc) |-> (eff_addr == {bank_ff, ior.f})) // RULE_04
    else $error("Bank select not applied");
  a_indexed_mode: assert property ((is_ior && !ior.acc && ext_ff && ior.f <= 8'h5f) |-> // RULE_05
    (eff_addr == ptr_ff[2] + {4'h0, ior.f}))
    else $error("Indexed literal offset address wrong");
  a_ptr_high: assert property ((state_ff == IOFP_EXEC && is_ld1 && ir_ff[5:4] != 2'h3) |=> // RULE_07
    (state_ff == IOFP_WAIT2) && (ptr_ff[sel_ff][11:8] == $past(ir_ff[3:0])))
    else $error("Pointer high byte not loaded first");
  a_ptr_low: assert property ((state_ff == IOFP_EXEC2 && ir_ff[15:8] == 8'hf0) |=> // RULE_07
    (ptr_ff[sel_ff][7:0] == $past(ir_ff[7:0])) && (state_ff == IOFP_IDLE))
    else $error("Pointer low byte not loaded second");
  a_sel_refused: assert property ((state_ff == IOFP_EXEC && is_ld1 && ir_ff[5:4] == 2'h3) |=> // RULE_06
    (state_ff == IOFP_IDLE) && bad_ff && $stable(ptr_ff[0]) && $stable(ptr_ff[1]) && $stable(ptr_ff[2]))
    else $error("Pointer selector 3 not refused");
endmodule

// file: iofp_core_tb.sv
/*
  Self-checking bench of the OR-into-file and pointer-load block, driven only over APB.
  Assumes the package, the constants header and the core are compiled before this file.
*/
`timescale 1ns/10ps
`include "iofp_cfg.svh"
module iofp_core_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  int          n_fail;
  int          n_compared;
  localparam logic [31:0] ALL = 32'hffff_ffff;

  iofp_core DUT (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // The clock runs at 20 MHz.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that samples pready high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // The slave answers in the second access cycle; only the watchdog ends a hang.
    chk("pready wait", 32'h2, 32'(n));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
    chk("write pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(name, exp, q & m);
    chk("read pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(`IOFP_OFS_RAMADDR, {20'h0, a});
    wr(`IOFP_OFS_RAMDATA, {24'h0, d});
  endtask

  task automatic mem_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
    wr(`IOFP_OFS_RAMADDR, {20'h0, a});
    rdc(name, `IOFP_OFS_RAMDATA, {24'h0, exp}, ALL);
  endtask

  // OR-into-file instruction word with its destination, access and address fields.
  function automatic logic [31:0] ior(input logic d, input logic a, input logic [7:0] f);
    return {16'h0, `IOFP_OP_IOR, d, a, f};
  endfunction

  // Reset values, a read of the write-only instruction port and an unmapped offset.
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rdc("work", `IOFP_OFS_WORK, 32'h0, ALL);
    rdc("status", `IOFP_OFS_STATUS, 32'h0, ALL);
    rdc("bank", `IOFP_OFS_BANK, 32'h0, ALL);
    rdc("cfg", `IOFP_OFS_CFG, 32'h0, ALL);
    rdc("ptr2", `IOFP_OFS_PTR0 + 8'h08, 32'h0, ALL);
    rdc("instr", `IOFP_OFS_INSTR, 32'h0, ALL);
    xfer(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  // Result to the work register through the selected bank; bank 0 holds a decoy.
  task automatic t_or_work();
    wr(`IOFP_OFS_BANK, 32'h3);
    mem_wr(12'h010, 8'h44);
    mem_wr(12'h310, 8'h13);
    wr(`IOFP_OFS_WORK, 32'h80);
    wr(`IOFP_OFS_INSTR, ior(1'b0, 1'b1, 8'h10));
    rdc("work", `IOFP_OFS_WORK, 32'h93, ALL);
    rdc("flags", `IOFP_OFS_STATUS, 32'h2, ALL);
    mem_chk("file", 12'h310, 8'h13);
    mem_wr(12'h310, 8'h00);
    wr(`IOFP_OFS_WORK, 32'h0);
    wr(`IOFP_OFS_INSTR, ior(1'b0, 1'b1, 8'h10));
    rdc("zero flag", `IOFP_OFS_STATUS, 32'h1, ALL);
  endtask

  // Result back into the file register, work register untouched.
  task automatic t_or_file();
    mem_wr(12'h310, 8'h30);
    wr(`IOFP_OFS_WORK, 32'h0c);
    wr(`IOFP_OFS_INSTR, ior(1'b1, 1'b1, 8'h10));
    mem_chk("file", 12'h310, 8'h3c);
    rdc("work", `IOFP_OFS_WORK, 32'h0c, ALL);
    rdc("flags", `IOFP_OFS_STATUS, 32'h0, ALL);
  endtask

  // Access bank ignores the bank select register.
  task automatic t_access();
    mem_wr(12'hf80, 8'h01);
    mem_wr(12'h380, 8'h00);
    wr(`IOFP_OFS_WORK, 32'h40);
    wr(`IOFP_OFS_INSTR, ior(1'b1, 1'b0, 8'h80));
    mem_chk("access bank", 12'hf80, 8'h41);
    mem_chk("banked", 12'h380, 8'h00);
  endtask

  // Extended set: offsets up to 95 are indexed from pointer 2, 96 is direct.
  task automatic t_indexed();
    logic [7:0]  f [2] = '{8'h5f, 8'h60};
    logic [11:0] a [2] = '{12'h15f, 12'hf60};
    wr(`IOFP_OFS_CFG, 32'h1);
    wr(`IOFP_OFS_PTR0 + 8'h08, 32'h100);
    wr(`IOFP_OFS_WORK, 32'h02);
    for (int i = 0; i < 2; i++) begin
      mem_wr(a[i], 8'h11);
      wr(`IOFP_OFS_INSTR, ior(1'b1, 1'b0, f[i]));
      mem_chk("indexed", a[i], 8'h13);
    end
    wr(`IOFP_OFS_CFG, 32'h0);
  endtask

  // Pointer load on every selector, high byte first, then a refused selector.
  task automatic t_ptr();
    logic [11:0] k [3] = '{12'h3ab, 12'h000, 12'hfff};
    logic [7:0]  p;
    for (int s = 0; s < 3; s++) begin
      p = `IOFP_OFS_PTR0 + 8'(4 * s);
      wr(p, 32'h5a5);
      wr(`IOFP_OFS_INSTR, {16'h0, `IOFP_OP_LDPTR1, 2'b00, 2'(s), k[s][11:8]});
      rdc("ptr first", p, {20'h0, k[s][11:8], 8'ha5}, ALL);
      rdc("pending", `IOFP_OFS_STATUS, 32'h4, 32'hc);
      wr(`IOFP_OFS_INSTR, {16'h0, `IOFP_OP_LDPTR2, k[s][7:0]});
      rdc("ptr", p, {20'h0, k[s]}, ALL);
      rdc("done", `IOFP_OFS_STATUS, 32'h0, 32'hc);
    end
    wr(`IOFP_OFS_PTR0, 32'h123);
    wr(`IOFP_OFS_INSTR, {16'h0, `IOFP_OP_LDPTR1, 2'b00, `IOFP_SEL_BAD, 4'h7});
    rdc("bad sel", `IOFP_OFS_STATUS, 32'h8, 32'hc);
    rdc("ptr0 kept", `IOFP_OFS_PTR0, 32'h123, ALL);
    wr(`IOFP_OFS_STATUS, 32'h0);
    rdc("bad clear", `IOFP_OFS_STATUS, 32'h0, 32'hc);
    // A wrong second word is refused and leaves the low byte alone.
    wr(`IOFP_OFS_INSTR, {16'h0, `IOFP_OP_LDPTR1, 2'b00, 2'h1, 4'h9});
    wr(`IOFP_OFS_INSTR, ior(1'b0, 1'b1, 8'h10));
    rdc("bad word2", `IOFP_OFS_STATUS, 32'h8, 32'hc);
    rdc("ptr1 low kept", `IOFP_OFS_PTR0 + 8'h04, 32'h900, ALL);
    wr(`IOFP_OFS_STATUS, 32'h0);
    // An unknown opcode is flagged as bad as well.
    wr(`IOFP_OFS_INSTR, 32'h0);
    rdc("bad opcode", `IOFP_OFS_STATUS, 32'h8, 32'hc);
    wr(`IOFP_OFS_STATUS, 32'h0);
  endtask

  // Reset is held for 16 cycles, then the scenarios run in turn.
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    n_fail  = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_or_work();
    t_or_file();
    t_access();
    t_indexed();
    t_ptr();
    report_and_stop();
  end

  // The scenarios need 90 transfers; far more time means a hang.
  initial begin
    #(50 * 20000);
    n_fail++;
    report_and_stop();
  end
endmodule
